// [dv/lcd_panel_data_mux_irq_props.sv]
// Purpose: Port-level properties of the panel data multiplexer.
// Assumes: Shadows the control word and irq mask from APB writes.
// Notes:   Bound to the top module after endmodule.
module lcd_panel_data_mux_irq_chk #(
  parameter int HSYNC_DOTS = 1
) (
  input wire logic        pclk, presetn, psel, penable, pwrite, pslverr, ser_valid,
  input wire logic        line_blank, last_line, dma_busy, dma_err_tgl, fifo_under_tgl,
  input wire logic        fifo_over_tgl, frame_upd_tgl, pixel_valid_strobe, line_sync_pulse, irq,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [23:0] ser_word, panel_data_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  ctrl;                                  // Shadow of mode and enable.
  logic [5:0]  mask;                                  // Shadow of the irq mask.
  logic [23:0] lanes;                                 // Lines the mode may drive.
  wire  [3:0]  tg = {frame_upd_tgl, fifo_over_tgl, fifo_under_tgl, dma_err_tgl};
  // Follows completed APB writes to control, enable and disable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 4'h0;
      mask <= 6'h00;
    end else if (psel && penable && pwrite) begin
      if (paddr == lcd_mux_pkg::OFF_CTRL) ctrl <= pwdata[3:0];
      if (paddr == lcd_mux_pkg::OFF_IER) mask <= mask | pwdata[5:0];
      if (paddr == lcd_mux_pkg::OFF_IDR) mask <= mask & ~pwdata[5:0];
    end
  end
  // Lane mask per mode.
  always_comb begin
    case (ctrl[2:0])
      3'h0: lanes = 24'h00000f;
      3'h1, 3'h2: lanes = 24'h0000ff;
      3'h3: lanes = 24'h00ffff;
      3'h4: lanes = 24'hffffff;
      3'h5: lanes = 24'hf8fcf8;
      default: lanes = 24'h000000;
    endcase
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_LANES: assert property ($stable(ctrl) |-> (panel_data_bus & ~lanes) == 24'h0)
    else $error("bus line driven outside the mode lanes");
  AST_QUIET: assert property (!pixel_valid_strobe |-> panel_data_bus == 24'h0)
    else $error("bus not low without strobe");
  AST_LOAD: assert property ($rose(pixel_valid_strobe) |-> $past(ser_valid))
    else $error("strobe rose without a valid word");
  AST_AM24: assert property (pixel_valid_strobe && ctrl == 4'hc && $changed(panel_data_bus)
    |-> panel_data_bus == $past(ser_word)) else $error("active matrix bytes misplaced");
  AST_SLVERR: assert property (psel && !penable && paddr > 8'h18 |=> pslverr)
    else $error("no error on unmapped address");
  AST_EVENT: assert property (|((tg ^ $past(tg)) & mask[3:0]) |-> ##[1:5] irq)
    else $error("event did not raise irq");
  AST_EOL: assert property ($rose(line_blank) && !dma_busy && mask[4] |-> ##[1:5] irq)
    else $error("end of line did not raise irq");
  AST_EOLL: assert property ($rose(line_blank) && last_line && !dma_busy && mask[5] |-> ##[1:5] irq)
    else $error("end of last line did not raise irq");
  AST_MASK: assert property (mask == 6'h00 |-> !irq)
    else $error("irq high with all sources masked");
  AST_SYNC: assert property ($rose(line_blank) && ctrl[3] |-> ##[1:5] line_sync_pulse)
    else $error("no line sync after blanking start");
  cover property ($rose(irq));
  cover property ($rose(line_sync_pulse));
  cover property (pslverr);
endmodule // lcd_panel_data_mux_irq_chk
bind lcd_panel_data_mux_irq lcd_panel_data_mux_irq_chk #(.HSYNC_DOTS(HSYNC_DOTS)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .pslverr, .ser_valid, .line_blank, .last_line,
  .dma_busy, .dma_err_tgl, .fifo_under_tgl, .fifo_over_tgl, .frame_upd_tgl,
  .pixel_valid_strobe, .line_sync_pulse, .irq, .paddr, .pwdata, .ser_word, .panel_data_bus);

// [dv/lcd_panel_model.sv]
// Purpose: Behavioural panel driver that latches the data bus.
// Assumes: Strobe and line sync are pclk-registered levels.
// Notes:   WIRED marks the bus lines the panel actually connects.
module lcd_panel_model #(
  parameter logic [23:0] WIRED = 24'hffffff           // Lines wired on the panel.
) (
  input  wire logic        pclk,
  input  wire logic [23:0] panel_data_bus,
  input  wire logic        pixel_valid_strobe,
  input  wire logic        line_sync_pulse,
  output logic      [23:0] pixel,
  output int               lines
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sync_q = 1'b0;                                // Last line sync level.
  initial begin
    pixel = 24'h000000;
    lines = 0;
  end
  // A narrow panel keeps only the component tops; lines count sync rises.
  always @(posedge pclk) begin
    if (pixel_valid_strobe) pixel <= panel_data_bus & WIRED;
    if (line_sync_pulse && !sync_q) lines <= lines + 1;
    sync_q <= line_sync_pulse;
  end
endmodule // lcd_panel_model

// [dv/test_lcd_panel_data_mux_irq.sv]
// Purpose: Self-checking bench for the panel data multiplexer.
// Assumes: Dot clock of 800 ns made from pclk edges; APB master task.
// Notes:   Checks lanes per mode, irq sources and mask registers.
module test_lcd_panel_data_mux_irq;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic ser_valid = 0, line_blank = 0, last_line = 0, dma_busy = 0, dot_clk;
  logic dma_err_tgl = 0, fifo_under_tgl = 0, fifo_over_tgl = 0, frame_upd_tgl = 0;
  logic pixel_valid_strobe, line_sync_pulse;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [23:0] ser_word = 24'h0, panel_data_bus, pixel;
  logic [2:0]  dcnt = 3'h0;                           // Dot clock divider.
  int          lines, n_fail = 0, check_count = 0;
  logic [23:0] exp [7] = '{24'h00000c, 24'h00003c, 24'h0000ac, 24'h005a3c, 24'h965a3c,
                           24'h905838, 24'h000000};   // Bus for word 965a3c per mode.
  lcd_panel_data_mux_irq u_lcd_panel_data_mux_irq (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .dot_clk, .ser_word, .ser_valid, .line_blank,
    .last_line, .dma_busy, .dma_err_tgl, .fifo_under_tgl, .fifo_over_tgl, .frame_upd_tgl,
    .panel_data_bus, .pixel_valid_strobe, .line_sync_pulse, .irq);
  lcd_panel_model u_lcd_panel_model (.pclk, .panel_data_bus, .pixel_valid_strobe,
    .line_sync_pulse, .pixel, .lines);
  initial begin
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) dcnt <= dcnt + 3'h1;
  assign dot_clk = dcnt[2];
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // One APB transfer; reads compare data, both compare the error flag.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic xe);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    if (!w) chk(prdata, x);
    chk({31'h0, pslverr}, {31'h0, xe});
  endtask
  task automatic close_out;
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, lcd_mux_pkg::OFF_IMR, 0, 32'h0, 0);
    apb(0, lcd_mux_pkg::OFF_ISR, 0, 32'h0, 0);
    apb(0, 8'h20, 0, 32'h0, 1);
    apb(1, 8'h20, 32'h1, 0, 1);
    ser_word <= 24'h965a3c; ser_valid <= 1'b1;
    // Mode 6 is an unused code and must leave every bus line low.
    for (int m = 0; m < 7; m++) begin
      apb(1, lcd_mux_pkg::OFF_CTRL, m, 0, 0);
      apb(1, lcd_mux_pkg::OFF_CTRL, 32'h8 | m, 0, 0);
      repeat (20) @(posedge pclk);
      chk(panel_data_bus, exp[m]);
      chk(pixel, exp[m]);
      chk(pixel_valid_strobe, 1);
    end
    ser_valid <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(panel_data_bus, 0);
    chk(pixel_valid_strobe, 0);
    apb(1, lcd_mux_pkg::OFF_IER, 32'h3f, 0, 0);
    {dma_err_tgl, fifo_under_tgl, fifo_over_tgl, frame_upd_tgl} <= 4'hf;
    last_line <= 1'b1; line_blank <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(0, lcd_mux_pkg::OFF_ISR, 0, 32'h3f, 0);
    chk(irq, 1);
    chk(lines, 1);
    apb(1, lcd_mux_pkg::OFF_IDR, 32'h3f, 0, 0);
    apb(0, lcd_mux_pkg::OFF_IMR, 0, 32'h0, 0);
    chk(irq, 0);
    apb(1, lcd_mux_pkg::OFF_IER, 32'h5, 0, 0);
    apb(1, lcd_mux_pkg::OFF_ICR, 32'h1, 0, 0);
    apb(0, lcd_mux_pkg::OFF_IMR, 0, 32'h5, 0);
    apb(1, lcd_mux_pkg::OFF_ISR, 32'h0, 0, 0);
    apb(0, lcd_mux_pkg::OFF_ISR, 0, 32'h3e, 0);
    chk(irq, 1);
    apb(1, lcd_mux_pkg::OFF_ICR, 32'h3f, 0, 0);
    apb(1, lcd_mux_pkg::OFF_CTRL, 32'hc, 0, 0);
    // A line of two dot periods on 24 lines each carries 48 bits.
    line_blank <= 1'b0; dma_busy <= 1'b1; ser_valid <= 1'b1;
    repeat (16) @(posedge pclk);
    line_blank <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(0, lcd_mux_pkg::OFF_ISR, 0, 32'h0, 0);
    apb(0, lcd_mux_pkg::OFF_LBITS, 0, 32'h30, 0);
    close_out;
  end
endmodule // test_lcd_panel_data_mux_irq

// [src/lcd_bus_mapper.sv]
// Purpose: Places a serializer word on the panel data bus lines per mode.
// Assumes: Serializer word holds upper/red in [7:0], lower/green in [15:8], blue in [23:16].
// Notes:   Purely combinational; the caller registers the result.
module lcd_bus_mapper (
  input  wire logic [2:0]  mode,
  input  wire logic [23:0] word,
  output logic      [23:0] mapped
);

  // ==========================================================
  // Lane placement
  // ==========================================================
  // Unused lanes stay low in every mode and for illegal codes.
  always_comb begin
    mapped = '0;
    case (mode)
      lcd_mux_pkg::MODE_PM4:    mapped[3:0] = word[3:0];
      lcd_mux_pkg::MODE_PM8:    mapped[7:0] = word[7:0];
      lcd_mux_pkg::MODE_DUAL8: begin
        mapped[3:0] = word[3:0];
        mapped[7:4] = word[11:8];
      end
      lcd_mux_pkg::MODE_DUAL16: begin
        mapped[7:0]  = word[7:0];
        mapped[15:8] = word[15:8];
      end
      lcd_mux_pkg::MODE_AM24:   mapped = {word[23:16], word[15:8], word[7:0]};
      lcd_mux_pkg::MODE_AM16: begin
        // Most significant component bits are kept.
        mapped[23:19] = word[23:19];
        mapped[15:10] = word[15:10];
        mapped[7:3]   = word[7:3];
      end
      default:                  mapped = '0;
    endcase
  end

endmodule // lcd_bus_mapper

// [src/lcd_event_sync.sv]
// Purpose: Two flip-flop synchroniser for every asynchronous input.
// Assumes: Toggle events stay stable at least two pclk periods.
// Notes:   The first stage is read only by the second stage.
module lcd_event_sync #(
  parameter int N = 8
) (
  input wire logic         pclk,
  input wire logic         presetn,
  lcd_sync_if.sync_side    port
);

  // ==========================================================
  // Synchroniser stages
  // ==========================================================
  logic [N-1:0] meta;                                 // First stage only.
  logic [N-1:0] next_meta;
  logic [N-1:0] next_synced;

  // Next values are simply the previous stage.
  always_comb begin
    next_meta   = port.raw;
    next_synced = meta;
  end

  // Both stages reset to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta        <= '0;
      port.synced <= '0;
    end else begin
      meta        <= next_meta;
      port.synced <= next_synced;
    end
  end

endmodule // lcd_event_sync

// [src/lcd_mux_pkg.sv]
// Purpose: Shared constants and types for the panel data multiplexer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Every offset and field position lives here, as do the mask and status reset values.
package lcd_mux_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam int         ADDR_W    = 8;               // Decoded address width.
  localparam logic [7:0] OFF_CTRL  = 8'h00;           // Mode and enable.
  localparam logic [7:0] OFF_IER   = 8'h04;           // irq_enable_reg, write only.
  localparam logic [7:0] OFF_IDR   = 8'h08;           // irq_disable_reg, write only.
  localparam logic [7:0] OFF_ICR   = 8'h0c;           // irq_clear_reg, write only.
  localparam logic [7:0] OFF_IMR   = 8'h10;           // irq_mask_reg, read only.
  localparam logic [7:0] OFF_ISR   = 8'h14;           // irq_status_reg, read only.
  localparam logic [7:0] OFF_LBITS = 8'h18;           // Bits of last line, read only.

  // ==========================================================
  // Field layout and reset values
  // ==========================================================
  localparam int         MODE_LSB  = 0;               // Mode field low bit in CTRL.
  localparam int         MODE_W    = 3;               // Mode field width.
  localparam int         EN_BIT    = 3;               // Output enable bit in CTRL.
  localparam int         NUM_IRQ   = 6;               // Interrupt sources.
  localparam int         LBITS_W   = 16;              // Line bit counter width.
  localparam int         BUS_W     = 24;              // Panel data bus width.
  localparam logic [5:0] MASK_RST  = 6'h00;           // All sources disabled.
  localparam logic [5:0] STAT_RST  = 6'h00;           // Nothing pending.

  // Interrupt bit positions in mask and status.
  localparam int IRQ_MEMERR = 0;
  localparam int IRQ_UNDER  = 1;
  localparam int IRQ_OVER   = 2;
  localparam int IRQ_EOF    = 3;
  localparam int IRQ_EOL    = 4;
  localparam int IRQ_EOLL   = 5;

  // Positions of the asynchronous inputs in the synchroniser vector.
  localparam int SY_MEMERR = 0;                       // Toggle per event.
  localparam int SY_UNDER  = 1;
  localparam int SY_OVER   = 2;
  localparam int SY_EOF    = 3;
  localparam int SY_BLANK  = 4;                       // Levels from here on.
  localparam int SY_LAST   = 5;
  localparam int SY_BUSY   = 6;
  localparam int SY_DOT    = 7;
  localparam int SY_N      = 8;

  // Panel organisation selected by the mode field.
  typedef enum logic [2:0] {
    MODE_PM4    = 3'h0,                               // 4-bit single scan.
    MODE_PM8    = 3'h1,                               // 8-bit single scan.
    MODE_DUAL8  = 3'h2,                               // 8-bit dual scan.
    MODE_DUAL16 = 3'h3,                               // 16-bit dual scan.
    MODE_AM24   = 3'h4,                               // 24-bit active matrix.
    MODE_AM16   = 3'h5                                // 16-bit active matrix.
  } panel_mode_t;

  // Line sync state, one-hot.
  typedef enum logic [1:0] {
    LS_IDLE  = 2'b01,
    LS_PULSE = 2'b10
  } line_state_t;

  // Number of bus lines carrying data per dot in each mode.
  function automatic logic [4:0] bus_bits(input logic [2:0] mode);
    case (mode)
      MODE_PM4:    bus_bits = 5'h04;
      MODE_PM8:    bus_bits = 5'h08;
      MODE_DUAL8:  bus_bits = 5'h08;
      MODE_DUAL16: bus_bits = 5'h10;
      MODE_AM24:   bus_bits = 5'h18;
      MODE_AM16:   bus_bits = 5'h10;
      default:     bus_bits = 5'h00;
    endcase
  endfunction

endpackage

// [src/lcd_panel_data_mux_irq.sv]
// Purpose: Panel data bus multiplexer, line sync and interrupt registers.
// Assumes: ser_word and ser_valid are on pclk and held for a whole dot period.
// Notes:   The dot clock and all event inputs are synchronised before use.
//
// Function
// - 4-bit single scan uses lines 3..0
// - 8-bit single scan uses lines 7..0
// - 8-bit dual: upper 3..0, lower 7..4
// - 16-bit dual: upper 7..0, lower 15..8
// - data shifts out line by line
// - 24-bit active: blue, green, red bytes
// - 16-bit active: 5/6/5 on component tops
// - six sources synchronised to core clock
// - memory error on DMA bus error
// - underflow on read of empty FIFO
// - overwrite on write to full FIFO
// - end of frame on pointer update
// - end of line at blanking, DMA idle
// - end of last line likewise
// - separate enable, disable, clear registers
// - readable mask and status registers
// - valid strobe marks valid bus data
// - line sync pulse after each line
module lcd_panel_data_mux_irq #(
  parameter int HSYNC_DOTS = 1                        // Line sync width in dots.
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [lcd_mux_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             dot_clk,
  input  wire logic [23:0]                      ser_word,
  input  wire logic                             ser_valid,
  input  wire logic                             line_blank,
  input  wire logic                             last_line,
  input  wire logic                             dma_busy,
  input  wire logic                             dma_err_tgl,
  input  wire logic                             fifo_under_tgl,
  input  wire logic                             fifo_over_tgl,
  input  wire logic                             frame_upd_tgl,
  output logic      [lcd_mux_pkg::BUS_W-1:0]    panel_data_bus,
  output logic                                  pixel_valid_strobe,
  output logic                                  line_sync_pulse,
  output logic                                  irq
);

  // ==========================================================
  // Synchronisers
  // ==========================================================
  lcd_sync_if #(.N(lcd_mux_pkg::SY_N)) sy ();         // Async inputs and results.
  logic [lcd_mux_pkg::SY_N-1:0] sy_prev;              // Previous synced values.
  logic [lcd_mux_pkg::SY_N-1:0] sy_edge;              // Change seen this cycle.

  // Every event input and the dot clock pass two flip-flops before use.
  always_comb begin
    sy.raw                        = '0;
    sy.raw[lcd_mux_pkg::SY_MEMERR] = dma_err_tgl;
    sy.raw[lcd_mux_pkg::SY_UNDER]  = fifo_under_tgl;
    sy.raw[lcd_mux_pkg::SY_OVER]   = fifo_over_tgl;
    sy.raw[lcd_mux_pkg::SY_EOF]    = frame_upd_tgl;
    sy.raw[lcd_mux_pkg::SY_BLANK]  = line_blank;
    sy.raw[lcd_mux_pkg::SY_LAST]   = last_line;
    sy.raw[lcd_mux_pkg::SY_BUSY]   = dma_busy;
    sy.raw[lcd_mux_pkg::SY_DOT]    = dot_clk;
  end

  lcd_event_sync #(.N(lcd_mux_pkg::SY_N)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .port    (sy.sync_side)
  );

  // A third stage remembers the last synced value for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy_prev <= '0;
    end else begin
      sy_prev <= sy.synced;
    end
  end

  // ==========================================================
  // Event decode
  // ==========================================================
  logic                           blank_s;            // Synced blanking level.
  logic                           blank_rise;         // Blanking has just begun.
  logic                           dot_rise;           // Dot clock rising edge.
  logic [lcd_mux_pkg::NUM_IRQ-1:0] evt;               // One-cycle source events.

  // Toggle inputs mark one event per change; blanking is a level.
  always_comb begin
    sy_edge    = sy.synced ^ sy_prev;
    blank_s    = sy.synced[lcd_mux_pkg::SY_BLANK];
    blank_rise = blank_s & ~sy_prev[lcd_mux_pkg::SY_BLANK];
    dot_rise   = sy.synced[lcd_mux_pkg::SY_DOT] & ~sy_prev[lcd_mux_pkg::SY_DOT];
    evt        = '0;
    evt[lcd_mux_pkg::IRQ_MEMERR] = sy_edge[lcd_mux_pkg::SY_MEMERR];
    evt[lcd_mux_pkg::IRQ_UNDER]  = sy_edge[lcd_mux_pkg::SY_UNDER];
    evt[lcd_mux_pkg::IRQ_OVER]   = sy_edge[lcd_mux_pkg::SY_OVER];
    evt[lcd_mux_pkg::IRQ_EOF]    = sy_edge[lcd_mux_pkg::SY_EOF];
    evt[lcd_mux_pkg::IRQ_EOL]    = blank_rise
                                   & ~sy.synced[lcd_mux_pkg::SY_BUSY];
    evt[lcd_mux_pkg::IRQ_EOLL]   = blank_rise & sy.synced[lcd_mux_pkg::SY_LAST]
                                   & ~sy.synced[lcd_mux_pkg::SY_BUSY];
  end

  // ==========================================================
  // APB register file
  // ==========================================================
  logic [2:0]                      mode;              // Panel organisation.
  logic                            enable;            // Drives the panel bus.
  logic [lcd_mux_pkg::NUM_IRQ-1:0] irq_mask;          // Enabled sources.
  logic [lcd_mux_pkg::NUM_IRQ-1:0] irq_status;        // Pending sources.
  logic [lcd_mux_pkg::LBITS_W-1:0] last_bits;         // Bits of the last line.
  logic [2:0]                      next_mode;
  logic                            next_enable;
  logic [lcd_mux_pkg::NUM_IRQ-1:0] next_mask;
  logic [lcd_mux_pkg::NUM_IRQ-1:0] next_status;
  logic [31:0]                     next_prdata;
  logic                            next_pslverr;
  logic                            setup;             // Setup phase of a transfer.
  logic                            wr_acc;            // Write access phase.
  logic                            mapped_addr;       // Address is decoded.
  logic [lcd_mux_pkg::NUM_IRQ-1:0] wbits;             // Written source bits.

  // Zero wait states: read data is prepared during the setup cycle.
  always_comb begin
    pready       = 1'b1;
    setup        = psel & ~penable;
    wr_acc       = psel & penable & pwrite;
    wbits        = pwdata[lcd_mux_pkg::NUM_IRQ-1:0];
    mapped_addr  = (paddr == lcd_mux_pkg::OFF_CTRL) || (paddr == lcd_mux_pkg::OFF_IER)
                || (paddr == lcd_mux_pkg::OFF_IDR)  || (paddr == lcd_mux_pkg::OFF_ICR)
                || (paddr == lcd_mux_pkg::OFF_IMR)  || (paddr == lcd_mux_pkg::OFF_ISR)
                || (paddr == lcd_mux_pkg::OFF_LBITS);
    next_mode    = mode;
    next_enable  = enable;
    next_mask    = irq_mask;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (wr_acc && paddr == lcd_mux_pkg::OFF_CTRL) begin
      next_mode   = pwdata[lcd_mux_pkg::MODE_LSB +: lcd_mux_pkg::MODE_W];
      next_enable = pwdata[lcd_mux_pkg::EN_BIT];
    end
    if (wr_acc && paddr == lcd_mux_pkg::OFF_IER) begin
      next_mask = irq_mask | wbits;
    end
    if (wr_acc && paddr == lcd_mux_pkg::OFF_IDR) begin
      next_mask = irq_mask & ~wbits;
    end
    // A new event wins over a clear in the same cycle.
    next_status = irq_status | evt;
    if (wr_acc && paddr == lcd_mux_pkg::OFF_ICR) begin
      next_status = (irq_status & ~wbits) | evt;
    end
    if (setup) begin
      next_pslverr = ~mapped_addr;
      next_prdata  = '0;
      case (paddr)
        lcd_mux_pkg::OFF_CTRL: begin
          next_prdata[lcd_mux_pkg::MODE_LSB +: lcd_mux_pkg::MODE_W] = mode;
          next_prdata[lcd_mux_pkg::EN_BIT] = enable;
        end
        lcd_mux_pkg::OFF_IMR:   next_prdata[lcd_mux_pkg::NUM_IRQ-1:0] = irq_mask;
        lcd_mux_pkg::OFF_ISR:   next_prdata[lcd_mux_pkg::NUM_IRQ-1:0] = irq_status;
        lcd_mux_pkg::OFF_LBITS: next_prdata[lcd_mux_pkg::LBITS_W-1:0] = last_bits;
        default:                next_prdata = '0;
      endcase
    end
  end

  // Register state; the interrupt output is registered as well.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode       <= lcd_mux_pkg::MODE_PM4;
      enable     <= 1'b0;
      irq_mask   <= lcd_mux_pkg::MASK_RST;
      irq_status <= lcd_mux_pkg::STAT_RST;
      prdata     <= '0;
      pslverr    <= 1'b0;
      irq        <= 1'b0;
    end else begin
      mode       <= next_mode;
      enable     <= next_enable;
      irq_mask   <= next_mask;
      irq_status <= next_status;
      prdata     <= next_prdata;
      pslverr    <= next_pslverr;
      irq        <= |(next_status & next_mask);
    end
  end

  // ==========================================================
  // Panel data path
  // ==========================================================
  logic [23:0]                     mapped;            // Word placed on its lanes.
  logic [23:0]                     next_bus;
  logic                            next_valid;
  logic [lcd_mux_pkg::LBITS_W-1:0] bit_cnt;           // Bits sent in this line.
  logic [lcd_mux_pkg::LBITS_W-1:0] next_bit_cnt;
  logic [lcd_mux_pkg::LBITS_W-1:0] next_last_bits;

  lcd_bus_mapper u_map (
    .mode   (mode),
    .word   (ser_word),
    .mapped (mapped)
  );

  // One word per dot edge, outside blanking; each word adds the
  // bus_bits width of the mode to the line count.
  always_comb begin
    next_bus       = panel_data_bus;
    next_valid     = pixel_valid_strobe;
    next_bit_cnt   = bit_cnt;
    next_last_bits = last_bits;
    if (dot_rise) begin
      if (enable && ser_valid && !blank_s) begin
        next_bus     = mapped;
        next_valid   = 1'b1;
        next_bit_cnt = bit_cnt
                     + {{(lcd_mux_pkg::LBITS_W-5){1'b0}}, lcd_mux_pkg::bus_bits(mode)};
      end else begin
        next_bus   = '0;
        next_valid = 1'b0;
      end
    end
    if (blank_rise) begin
      next_last_bits = bit_cnt;
      next_bit_cnt   = '0;
    end
    if (!enable) begin
      next_bus   = '0;
      next_valid = 1'b0;
    end
  end

  // Panel outputs come straight from flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_data_bus     <= '0;
      pixel_valid_strobe <= 1'b0;
      bit_cnt            <= '0;
      last_bits          <= '0;
    end else begin
      panel_data_bus     <= next_bus;
      pixel_valid_strobe <= next_valid;
      bit_cnt            <= next_bit_cnt;
      last_bits          <= next_last_bits;
    end
  end

  // ==========================================================
  // Line sync
  // ==========================================================
  localparam logic [7:0] HS_DOTS = 8'(HSYNC_DOTS);    // Pulse length in dots.
  lcd_mux_pkg::line_state_t ls_state;
  lcd_mux_pkg::line_state_t next_ls_state;
  logic [7:0]               hs_cnt;                   // Dot edges left in pulse.
  logic [7:0]               next_hs_cnt;
  logic                     next_hsync;

  // Once a line has been shifted out and blanking begins, pulse.
  always_comb begin
    next_ls_state = ls_state;
    next_hs_cnt   = hs_cnt;
    next_hsync    = 1'b0;
    unique case (ls_state)
      lcd_mux_pkg::LS_IDLE: begin
        if (blank_rise && enable) begin
          next_ls_state = lcd_mux_pkg::LS_PULSE;
          next_hs_cnt   = HS_DOTS;
          next_hsync    = 1'b1;
        end
      end
      lcd_mux_pkg::LS_PULSE: begin
        next_hsync = 1'b1;
        if (dot_rise) begin
          next_hs_cnt = hs_cnt - 8'h01;
          if (hs_cnt <= 8'h01) begin
            next_ls_state = lcd_mux_pkg::LS_IDLE;
            next_hsync    = 1'b0;
          end
        end
      end
      default: begin
        next_ls_state = lcd_mux_pkg::LS_IDLE;
      end
    endcase
  end

  // Line sync state registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_state        <= lcd_mux_pkg::LS_IDLE;
      hs_cnt          <= '0;
      line_sync_pulse <= 1'b0;
    end else begin
      ls_state        <= next_ls_state;
      hs_cnt          <= next_hs_cnt;
      line_sync_pulse <= next_hsync;
    end
  end

endmodule // lcd_panel_data_mux_irq

// [src/lcd_sync_if.sv]
// Purpose: Carries asynchronous inputs to the synchroniser and back.
// Assumes: One bit per input, all from outside the pclk domain.
// Notes:   The synchronised side is safe for any logic on pclk.
interface lcd_sync_if #(parameter int N = 8);
  logic [N-1:0] raw;                                  // Unsynchronised inputs.
  logic [N-1:0] synced;                               // Second flip-flop outputs.
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface
